// ==== rtl/math_eval_pkg.sv ====
// constants shared by the chained math evaluator and its two-operand stage
// assumes all values are signed integers in the unit of their source block
package math_eval_pkg;
  localparam int DATA_W = 32;
  localparam int N_INST = 4;
  localparam int N_INPUTS = 5;
  localparam int N_STAGES = 4;
  localparam int N_SRC = 8;
  localparam int N_NUM = 8;
  localparam int SRC_W = 3;
  localparam int NUM_W = 4;
  localparam int OP_W = 4;
  localparam int WEIGHT_W = 16;
  localparam int WEIGHT_FRAC = 14;
  // nominal input span after rescaling
  localparam logic signed [63:0] IN_NOM = 64'sd1000;
  // full scale of every function result
  localparam logic signed [63:0] FULL_SCALE = 64'sd1000000;
  // weight of 1.0 in Q2.14; also the reset-free default a host should load
  localparam logic signed [WEIGHT_W-1:0] WEIGHT_ONE = 16'sh4000;
  localparam logic [SRC_W-1:0] SRC_UNUSED = 3'h0;
  // operator codes
  localparam logic [OP_W-1:0] OP_EQ = 4'h0;
  localparam logic [OP_W-1:0] OP_NE = 4'h1;
  localparam logic [OP_W-1:0] OP_GT = 4'h2;
  localparam logic [OP_W-1:0] OP_GE = 4'h3;
  localparam logic [OP_W-1:0] OP_LT = 4'h4;
  localparam logic [OP_W-1:0] OP_LE = 4'h5;
  localparam logic [OP_W-1:0] OP_OR = 4'h6;
  localparam logic [OP_W-1:0] OP_AND = 4'h7;
  localparam logic [OP_W-1:0] OP_XOR = 4'h8;
  localparam logic [OP_W-1:0] OP_ADD = 4'h9;
  localparam logic [OP_W-1:0] OP_SUB = 4'hA;
  localparam logic [OP_W-1:0] OP_MUL = 4'hB;
  localparam logic [OP_W-1:0] OP_DIV = 4'hC;
  localparam logic [OP_W-1:0] OP_MIN = 4'hD;
  localparam logic [OP_W-1:0] OP_MAX = 4'hE;
  localparam logic [OP_W-1:0] OP_ABSDIFF = 4'hF;
  localparam logic [OP_W-1:0] OP_LAST_LOGIC = 4'h8;
  // reset value of the result and range outputs
  localparam logic signed [DATA_W-1:0] RESULT_RST = 32'sh0;
endpackage : math_eval_pkg

// ==== rtl/math_evaluator.sv ====
// four chained math evaluators with input selection, scaling and output mapping
// assumes source values and settings come from logic on clk, so no synchronisers
//
// Function
// [RULE1] four independently configured evaluator instances
// [RULE2] five selectable inputs per instance
// [RULE3] inputs rescaled by min/max into -1000..1000
// [RULE4] each input weighted by -1.0..1.0
// [RULE5] four functions chained through first operand
// [RULE6] unused second operand passes first through
// [RULE7] codes 0-5 are relational compares
// [RULE8] codes 6-8 are OR, AND, XOR
// [RULE9] codes 9-12 are add, subtract, multiply, divide
// [RULE10] codes 13-15 are min, max, absolute difference
// [RULE11] boolean true means operand at least 1
// [RULE12] codes 0-8 give exactly 0 or 1
// [RULE13] arithmetic results saturate at plus/minus 1e6
// [RULE14] divide by zero gives plus 1e6
// [RULE15] final result mapped into output min/max
// [RULE16] output min/max reported as range limits
// [RULE17] chain recomputed whenever inputs change
`timescale 1ns/100ps
module math_evaluator #(
  parameter int N_INST = math_eval_pkg::N_INST
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // source values from other blocks, indexed by source type and number-1
  input wire logic signed [31:0] src_value [math_eval_pkg::N_SRC][math_eval_pkg::N_NUM],
  // per-input selection and scaling
  input wire logic [2:0] in_src [N_INST][math_eval_pkg::N_INPUTS],
  input wire logic [3:0] in_num [N_INST][math_eval_pkg::N_INPUTS],
  input wire logic signed [31:0] in_min [N_INST][math_eval_pkg::N_INPUTS],
  input wire logic signed [31:0] in_max [N_INST][math_eval_pkg::N_INPUTS],
  input wire logic signed [15:0] in_weight [N_INST][math_eval_pkg::N_INPUTS],
  // per-function operator
  input wire logic [3:0] op [N_INST][math_eval_pkg::N_STAGES],
  // output range
  input wire logic signed [31:0] out_min [N_INST],
  input wire logic signed [31:0] out_max [N_INST],
  // results and reported range limits
  output logic signed [31:0] result [N_INST],
  output logic signed [31:0] range_min [N_INST],
  output logic signed [31:0] range_max [N_INST]
);
  localparam int NI = math_eval_pkg::N_INPUTS;
  localparam int NS = math_eval_pkg::N_STAGES;

  function automatic logic signed [63:0] clamp(input logic signed [63:0] x,
                                               input logic signed [63:0] lim);
    clamp = (x > lim) ? lim : ((x < -lim) ? -lim : x);
  endfunction : clamp

  // degenerate ranges fall back to clamping so a bad setting cannot divide by zero
  function automatic logic signed [31:0] rescale(input logic signed [31:0] x,
                                                 input logic signed [31:0] mn,
                                                 input logic signed [31:0] mx);
    logic signed [63:0] span;
    logic signed [63:0] v;
    span = 64'(mx) - 64'(mn);
    v = 64'(x);
    if (span > 64'sh0) begin
      v = ((64'(x) - 64'(mn)) * 2 * math_eval_pkg::IN_NOM) / span - math_eval_pkg::IN_NOM;
    end
    rescale = 32'(clamp(v, math_eval_pkg::IN_NOM));
  endfunction : rescale

  // full-scale chain result to physical units; limited precision of integer divide
  function automatic logic signed [31:0] map_out(input logic signed [31:0] r,
                                                 input logic signed [31:0] mn,
                                                 input logic signed [31:0] mx);
    logic signed [63:0] num;
    num = (64'(r) + math_eval_pkg::FULL_SCALE) * (64'(mx) - 64'(mn));
    map_out = 32'(64'(mn) + num / (2 * math_eval_pkg::FULL_SCALE));
  endfunction : map_out

  logic signed [31:0] selected [N_INST][NI];
  logic signed [31:0] scaled [N_INST][NI];
  logic signed [31:0] weighted [N_INST][NI];
  logic signed [31:0] stage_a [N_INST][NS];
  logic signed [31:0] stage_b [N_INST][NS];
  logic stage_used [N_INST][NS];
  logic signed [31:0] stage_y [N_INST][NS];
  logic signed [31:0] mapped [N_INST];
  logic signed [31:0] result_reg [N_INST];
  logic signed [31:0] range_min_reg [N_INST];
  logic signed [31:0] range_max_reg [N_INST];

  genvar i;
  genvar j;
  genvar k;
  generate
    for (i = 0; i < N_INST; i++) begin : g_inst // RULE1
      for (j = 0; j < NI; j++) begin : g_in // RULE2
        logic [2:0] num_idx;
        logic num_ok;
        logic signed [63:0] wprod;
        logic signed [15:0] w_lim;
        assign num_ok = (in_num[i][j] != 4'h0) && (in_num[i][j] <= 4'h8);
        assign num_idx = num_ok ? 3'(in_num[i][j] - 4'h1) : 3'h0;
        assign selected[i][j] = (in_src[i][j] == math_eval_pkg::SRC_UNUSED || !num_ok) ?
                                32'sh0 : src_value[in_src[i][j]][num_idx];
        assign scaled[i][j] = rescale(selected[i][j], in_min[i][j], in_max[i][j]); // RULE3
        // out-of-range weights are held to +-1.0
        assign w_lim = 16'(clamp(64'(in_weight[i][j]), 64'(math_eval_pkg::WEIGHT_ONE)));
        assign wprod = 64'(scaled[i][j]) * 64'(w_lim);
        assign weighted[i][j] = 32'(wprod >>> math_eval_pkg::WEIGHT_FRAC); // RULE4
        // checks on every input of this instance
        unused_zero_a: assert property (@(posedge clk) disable iff (!resetn) // RULE2
          in_src[i][j] == math_eval_pkg::SRC_UNUSED |-> selected[i][j] == 32'sh0)
          else $error("unused input not read as zero");
        unity_weight_a: assert property (@(posedge clk) disable iff (!resetn) // RULE4
          w_lim == math_eval_pkg::WEIGHT_ONE |-> weighted[i][j] == scaled[i][j])
          else $error("unity weight changed the input");
      end

      for (k = 0; k < NS; k++) begin : g_stage
        if (k == 0) begin : g_first
          assign stage_a[i][k] = weighted[i][0]; // RULE5
        end else begin : g_next
          assign stage_a[i][k] = stage_y[i][k-1]; // RULE5
        end
        assign stage_b[i][k] = weighted[i][k+1];
        assign stage_used[i][k] = (in_src[i][k+1] != math_eval_pkg::SRC_UNUSED); // RULE6
        // operator decoding covers RULE7 RULE8 RULE9 RULE10 RULE11 RULE12 RULE13 RULE14
        math_op u_op (
          .first_operand(stage_a[i][k]),
          .second_operand(stage_b[i][k]),
          .op(op[i][k]),
          .b_used(stage_used[i][k]),
          .y(stage_y[i][k])
        );

        // local views of this stage; the checks re-derive each operator except min independently
        logic signed [31:0] ca;
        logic signed [31:0] cb;
        logic signed [31:0] cy;
        logic signed [63:0] diff;
        logic live;
        logic a_on;
        logic b_on;
        logic [3:0] code;
        assign ca = stage_a[i][k];
        assign cb = stage_b[i][k];
        assign cy = stage_y[i][k];
        assign diff = 64'(ca) - 64'(cb);
        assign live = stage_used[i][k];
        assign a_on = (ca >= 32'sh1); // RULE11
        assign b_on = (cb >= 32'sh1); // RULE11
        assign code = op[i][k];

        eq_code_a: assert property (@(posedge clk) disable iff (!resetn) // RULE7
          (live && code == math_eval_pkg::OP_EQ) |-> cy == ((ca == cb) ? 32'sh1 : 32'sh0))
          else $error("equal compare wrong");
        ne_code_a: assert property (@(posedge clk) disable iff (!resetn) // RULE7
          (live && code == math_eval_pkg::OP_NE) |-> cy == ((ca != cb) ? 32'sh1 : 32'sh0))
          else $error("not equal compare wrong");
        gt_code_a: assert property (@(posedge clk) disable iff (!resetn) // RULE7
          (live && code == math_eval_pkg::OP_GT) |-> cy == ((ca > cb) ? 32'sh1 : 32'sh0))
          else $error("greater compare wrong");
        ge_code_a: assert property (@(posedge clk) disable iff (!resetn) // RULE7
          (live && code == math_eval_pkg::OP_GE) |-> cy == ((ca >= cb) ? 32'sh1 : 32'sh0))
          else $error("greater or equal compare wrong");
        lt_code_a: assert property (@(posedge clk) disable iff (!resetn) // RULE7
          (live && code == math_eval_pkg::OP_LT) |-> cy == ((ca < cb) ? 32'sh1 : 32'sh0))
          else $error("less compare wrong");
        le_code_a: assert property (@(posedge clk) disable iff (!resetn) // RULE7
          (live && code == math_eval_pkg::OP_LE) |-> cy == ((ca <= cb) ? 32'sh1 : 32'sh0))
          else $error("less or equal compare wrong");
        or_code_a: assert property (@(posedge clk) disable iff (!resetn) // RULE8
          (live && code == math_eval_pkg::OP_OR) |-> cy == ((a_on || b_on) ? 32'sh1 : 32'sh0))
          else $error("boolean or wrong");
        and_code_a: assert property (@(posedge clk) disable iff (!resetn) // RULE8
          (live && code == math_eval_pkg::OP_AND) |-> cy == ((a_on && b_on) ? 32'sh1 : 32'sh0))
          else $error("boolean and wrong");
        xor_code_a: assert property (@(posedge clk) disable iff (!resetn) // RULE8
          (live && code == math_eval_pkg::OP_XOR) |-> cy == ((a_on != b_on) ? 32'sh1 : 32'sh0))
          else $error("boolean xor wrong");
        add_code_a: assert property (@(posedge clk) disable iff (!resetn) // RULE9
          (live && code == math_eval_pkg::OP_ADD)
          |-> cy == 32'(clamp(64'(ca) + 64'(cb), math_eval_pkg::FULL_SCALE)))
          else $error("sum wrong or not saturated");
        sub_code_a: assert property (@(posedge clk) disable iff (!resetn) // RULE9
          (live && code == math_eval_pkg::OP_SUB)
          |-> cy == 32'(clamp(diff, math_eval_pkg::FULL_SCALE)))
          else $error("difference wrong or not saturated");
        mul_code_a: assert property (@(posedge clk) disable iff (!resetn) // RULE13
          (live && code == math_eval_pkg::OP_MUL)
          |-> cy == 32'(clamp(64'(ca) * 64'(cb), math_eval_pkg::FULL_SCALE)))
          else $error("product wrong or not saturated");
        // a zero divisor is left to stage_div0_a
        div_code_a: assert property (@(posedge clk) disable iff (!resetn) // RULE9
          (live && code == math_eval_pkg::OP_DIV && cb != 32'sh0)
          |-> cy == 32'(clamp(64'(ca) / 64'(cb), math_eval_pkg::FULL_SCALE)))
          else $error("quotient wrong or not saturated");
        max_code_a: assert property (@(posedge clk) disable iff (!resetn) // RULE10
          (live && code == math_eval_pkg::OP_MAX) |-> cy >= ca && cy >= cb && (cy == ca || cy == cb))
          else $error("max operator picked wrong operand");
        abs_code_a: assert property (@(posedge clk) disable iff (!resetn) // RULE10
          (live && code == math_eval_pkg::OP_ABSDIFF)
          |-> cy == 32'(clamp((diff < 64'sh0) ? -diff : diff, math_eval_pkg::FULL_SCALE)))
          else $error("absolute difference wrong");
        stage_pass_a: assert property (@(posedge clk) disable iff (!resetn) // RULE6
          !live |-> cy == ca)
          else $error("unused stage altered its operand");
        bool_out_a: assert property (@(posedge clk) disable iff (!resetn) // RULE12
          (live && code <= math_eval_pkg::OP_LAST_LOGIC) |-> (cy == 32'sh0 || cy == 32'sh1))
          else $error("logic operator gave non boolean result");
        stage_sat_a: assert property (@(posedge clk) disable iff (!resetn) // RULE13
          cy <= 32'(math_eval_pkg::FULL_SCALE) && cy >= 32'(-math_eval_pkg::FULL_SCALE))
          else $error("stage result beyond full scale");
        stage_div0_a: assert property (@(posedge clk) disable iff (!resetn) // RULE14
          (live && code == math_eval_pkg::OP_DIV && cb == 32'sh0)
          |-> cy == 32'(math_eval_pkg::FULL_SCALE))
          else $error("zero divisor did not give full scale");
      end

      assign mapped[i] = map_out(stage_y[i][NS-1], out_min[i], out_max[i]); // RULE15

      // whole chain resampled every enabled cycle, so any input change shows next edge
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          result_reg[i] <= math_eval_pkg::RESULT_RST;
          range_min_reg[i] <= math_eval_pkg::RESULT_RST;
          range_max_reg[i] <= math_eval_pkg::RESULT_RST;
        end else if (ce) begin
          result_reg[i] <= mapped[i]; // RULE17
          range_min_reg[i] <= out_min[i]; // RULE16
          range_max_reg[i] <= out_max[i]; // RULE16
        end
      end

      assign result[i] = result_reg[i];
      assign range_min[i] = range_min_reg[i];
      assign range_max[i] = range_max_reg[i];

      // checks on input scaling, the chain links, stages 0, 1 and 3, and on the registered outputs
      input_range_a: assert property (@(posedge clk) disable iff (!resetn) // RULE3
        scaled[i][0] <= 32'sd1000 && scaled[i][0] >= -32'sd1000)
        else $error("scaled input out of nominal range");
      weight_bound_a: assert property (@(posedge clk) disable iff (!resetn) // RULE4
        (weighted[i][1] <= 32'sd1000) && (weighted[i][1] >= -32'sd1000))
        else $error("weighted input grew beyond scaled range");
      chain_link_a: assert property (@(posedge clk) disable iff (!resetn) // RULE5
        stage_a[i][2] == stage_y[i][1] && stage_a[i][0] == weighted[i][0])
        else $error("chain not linked through first operand");
      pass_unused_a: assert property (@(posedge clk) disable iff (!resetn) // RULE6
        !stage_used[i][1] |-> stage_y[i][1] == stage_a[i][1])
        else $error("unused stage altered its operand");
      logic_result_a: assert property (@(posedge clk) disable iff (!resetn) // RULE12
        (stage_used[i][0] && op[i][0] <= math_eval_pkg::OP_LAST_LOGIC)
        |-> (stage_y[i][0] == 32'sd0 || stage_y[i][0] == 32'sd1))
        else $error("logic operator gave non boolean result");
      min_select_a: assert property (@(posedge clk) disable iff (!resetn) // RULE10
        (stage_used[i][0] && op[i][0] == math_eval_pkg::OP_MIN)
        |-> stage_y[i][0] == ((stage_a[i][0] < stage_b[i][0]) ? stage_a[i][0] : stage_b[i][0]))
        else $error("min operator picked wrong operand");
      sat_bound_a: assert property (@(posedge clk) disable iff (!resetn) // RULE13
        stage_y[i][3] <= 32'sd1000000 && stage_y[i][3] >= -32'sd1000000)
        else $error("chain result beyond full scale");
      div_zero_a: assert property (@(posedge clk) disable iff (!resetn) // RULE14
        (stage_used[i][0] && op[i][0] == math_eval_pkg::OP_DIV && stage_b[i][0] == 32'sd0)
        |-> stage_y[i][0] == 32'sd1000000)
        else $error("zero divisor did not give full scale");
      out_update_a: assert property (@(posedge clk) disable iff (!resetn) // RULE17
        ce |=> result[i] == $past(mapped[i]))
        else $error("result not refreshed from current chain");
      out_hold_a: assert property (@(posedge clk) disable iff (!resetn) // RULE17
        !ce |=> $stable(result[i]))
        else $error("result moved while clock enable low");
      range_report_a: assert property (@(posedge clk) disable iff (!resetn) // RULE16
        ce |=> range_min[i] == $past(out_min[i]) && range_max[i] == $past(out_max[i]))
        else $error("reported range differs from output range");
      map_ends_a: assert property (@(posedge clk) disable iff (!resetn) // RULE15
        (ce && stage_y[i][3] == -32'sd1000000) |=> result[i] == $past(out_min[i]))
        else $error("negative full scale not mapped to output minimum");
      // output mapping at the top end and at mid scale
      map_top_a: assert property (@(posedge clk) disable iff (!resetn) // RULE15
        (ce && stage_y[i][3] == 32'(math_eval_pkg::FULL_SCALE))
        |=> result[i] == $past(out_max[i]))
        else $error("positive full scale not mapped to output maximum");
      map_mid_a: assert property (@(posedge clk) disable iff (!resetn) // RULE15
        (ce && stage_y[i][3] == 32'sh0)
        |=> result[i] == $past(32'(64'(out_min[i]) + (64'(out_max[i]) - 64'(out_min[i])) / 2)))
        else $error("zero chain result not mapped to mid range");
      range_hold_a: assert property (@(posedge clk) disable iff (!resetn) // RULE16
        !ce |=> $stable(range_min[i]) && $stable(range_max[i]))
        else $error("reported range moved while clock enable low");

      div_zero_c: cover property (@(posedge clk) disable iff (!resetn)
        stage_used[i][0] && op[i][0] == math_eval_pkg::OP_DIV && stage_b[i][0] == 32'sd0);
      saturate_c: cover property (@(posedge clk) disable iff (!resetn)
        stage_y[i][3] == 32'sd1000000);
      passthru_c: cover property (@(posedge clk) disable iff (!resetn)
        !stage_used[i][1] && !stage_used[i][2] && !stage_used[i][3]);
      chain_full_c: cover property (@(posedge clk) disable iff (!resetn)
        stage_used[i][1] && stage_used[i][2] && stage_used[i][3]);
      hold_c: cover property (@(posedge clk) disable iff (!resetn)
        !ce);
    end
  endgenerate
endmodule : math_evaluator

// ==== rtl/math_op.sv ====
// one two-operand function of the chain, purely combinational
// assumes operands already scaled; the caller registers the chain result
`timescale 1ns/100ps
module math_op (
  // operands
  input wire logic signed [31:0] first_operand,
  input wire logic signed [31:0] second_operand,
  // control
  input wire logic [3:0] op,
  input wire logic b_used,
  // result
  output logic signed [31:0] y
);
  logic signed [63:0] wa;
  logic signed [63:0] wb;
  logic signed [63:0] r;
  logic a_true;
  logic b_true;

  assign wa = {{32{first_operand[31]}}, first_operand};
  assign wb = {{32{second_operand[31]}}, second_operand};
  assign a_true = (first_operand >= 32'sd1);
  assign b_true = (second_operand >= 32'sd1);

  always_comb begin
    r = 64'sh0;
    unique case (op)
      math_eval_pkg::OP_EQ: r = {63'h0, wa == wb};
      math_eval_pkg::OP_NE: r = {63'h0, wa != wb};
      math_eval_pkg::OP_GT: r = {63'h0, wa > wb};
      math_eval_pkg::OP_GE: r = {63'h0, wa >= wb};
      math_eval_pkg::OP_LT: r = {63'h0, wa < wb};
      math_eval_pkg::OP_LE: r = {63'h0, wa <= wb};
      math_eval_pkg::OP_OR: r = {63'h0, a_true | b_true};
      math_eval_pkg::OP_AND: r = {63'h0, a_true & b_true};
      math_eval_pkg::OP_XOR: r = {63'h0, a_true ^ b_true};
      math_eval_pkg::OP_ADD: r = wa + wb;
      math_eval_pkg::OP_SUB: r = wa - wb;
      math_eval_pkg::OP_MUL: r = wa * wb;
      // a zero divisor yields positive full scale
      math_eval_pkg::OP_DIV: r = (wb == 64'sh0) ? math_eval_pkg::FULL_SCALE : wa / wb;
      math_eval_pkg::OP_MIN: r = (wa < wb) ? wa : wb;
      math_eval_pkg::OP_MAX: r = (wa > wb) ? wa : wb;
      math_eval_pkg::OP_ABSDIFF: r = (wa > wb) ? wa - wb : wb - wa;
    endcase
  end

  always_comb begin
    if (!b_used) begin
      y = first_operand;
    end else if (r > math_eval_pkg::FULL_SCALE) begin
      y = 32'(math_eval_pkg::FULL_SCALE);
    end else if (r < -math_eval_pkg::FULL_SCALE) begin
      y = 32'(-math_eval_pkg::FULL_SCALE);
    end else begin
      y = r[31:0];
    end
  end
endmodule : math_op

// ==== testbench/tb.sv ====
// self-checking bench for the four chained math evaluators
// assumes a 50 MHz clock and a result registered on the sampling edge
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("wrong value %s expected %0d seen %0d", nm, exp, got); end end
module tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic signed [31:0] src_value [8][8];
  logic [2:0] in_src [4][5];
  logic [3:0] in_num [4][5];
  logic signed [31:0] in_min [4][5];
  logic signed [31:0] in_max [4][5];
  logic signed [15:0] in_weight [4][5];
  logic [3:0] op [4][4];
  logic signed [31:0] out_min [4];
  logic signed [31:0] out_max [4];
  logic signed [31:0] result [4];
  logic signed [31:0] range_min [4];
  logic signed [31:0] range_max [4];
  int err_total = 0;
  int num_checks = 0;
  // operand pairs: plain, equal, negative against positive, divide by zero, boolean threshold
  logic signed [63:0] pa [5] = '{5, 3, -2, 0, 1};
  logic signed [63:0] pb [5] = '{3, 3, 4, 0, 0};

  always #10 clk = ~clk;

  math_evaluator u_dut (.clk(clk), .resetn(resetn), .ce(ce), .src_value(src_value),
    .in_src(in_src), .in_num(in_num), .in_min(in_min), .in_max(in_max),
    .in_weight(in_weight), .op(op), .out_min(out_min), .out_max(out_max),
    .result(result), .range_min(range_min), .range_max(range_max));

  // own reference of one stage, saturated after every function
  function automatic logic signed [63:0] ev(input int o, input logic signed [63:0] a,
                                            input logic signed [63:0] b);
    logic signed [63:0] r;
    case (o)
      0: r = 64'(a == b);
      1: r = 64'(a != b);
      2: r = 64'(a > b);
      3: r = 64'(a >= b);
      4: r = 64'(a < b);
      5: r = 64'(a <= b);
      6: r = 64'((a >= 1) || (b >= 1));
      7: r = 64'((a >= 1) && (b >= 1));
      8: r = 64'((a >= 1) ^ (b >= 1));
      9: r = a + b;
      10: r = a - b;
      11: r = a * b;
      12: r = (b == 0) ? 1000000 : a / b;
      13: r = (a < b) ? a : b;
      14: r = (a > b) ? a : b;
      default: r = (a > b) ? a - b : b - a;
    endcase
    if (r > 1000000) r = 1000000;
    if (r < -1000000) r = -1000000;
    return r;
  endfunction : ev

  // inputs change on the falling edge, results are read one falling edge later
  task automatic step();
    @(posedge clk);
    @(negedge clk);
  endtask : step

  // identity scaling and a +-1e6 output range make the result equal the chain value
  task automatic defaults();
    for (int i = 0; i < 4; i++) begin
      out_min[i] = -1000000;
      out_max[i] = 1000000;
      for (int k = 0; k < 5; k++) begin
        in_src[i][k] = 3'h0;
        in_num[i][k] = 4'(k + 1);
        in_min[i][k] = -1000;
        in_max[i][k] = 1000;
        in_weight[i][k] = math_eval_pkg::WEIGHT_ONE;
      end
      for (int k = 0; k < 4; k++) op[i][k] = 4'h0;
    end
    for (int t = 0; t < 8; t++) for (int n = 0; n < 8; n++) src_value[t][n] = 32'sh0;
  endtask : defaults

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  // about a hundred cycles are needed; this is far beyond that
  initial begin
    #200000;
    err_total++;
    stop_test();
  end

  initial begin
    defaults();
    repeat (6) @(negedge clk);
    `CHK("result in reset", math_eval_pkg::RESULT_RST, result[0])
    resetn = 1'b1;
    in_src[0][0] = 3'h1;
    in_src[0][1] = 3'h1;
    for (int o = 0; o < 16; o++) begin
      for (int p = 0; p < 5; p++) begin
        src_value[1][0] = 32'(pa[p]);
        src_value[1][1] = 32'(pb[p]);
        op[0][0] = 4'(o);
        step();
        `CHK("operator result", ev(o, pa[p], pb[p]), result[0])
      end
    end
    $display("test operators done");
    // add saturates, so the sub stage starts from 1e6 rather than 1e6+1000
    for (int k = 0; k < 5; k++) in_src[0][k] = 3'h1;
    for (int k = 0; k < 4; k++) src_value[1][k] = 1000;
    src_value[1][4] = 2;
    op[0][0] = math_eval_pkg::OP_MUL;
    op[0][1] = math_eval_pkg::OP_ADD;
    op[0][2] = math_eval_pkg::OP_SUB;
    op[0][3] = math_eval_pkg::OP_DIV;
    step();
    `CHK("chain result", 499500, result[0])
    in_src[0][3] = 3'h0;
    step();
    `CHK("unused stage", 500000, result[0])
    $display("test chain done");
    defaults();
    in_src[0][0] = 3'h1;
    in_src[0][1] = 3'h1;
    op[0][0] = math_eval_pkg::OP_ADD;
    in_min[0][0] = 0;
    in_max[0][0] = 10000;
    src_value[1][0] = 2500;
    src_value[1][1] = -7;
    in_weight[0][1] = 16'sh2000;
    step();
    // 2500 of 0..10000 gives -500; -7 at half weight floors to -4
    `CHK("scaled sum", -504, result[0])
    in_weight[0][1] = 16'shC000;
    step();
    `CHK("negative weight", -493, result[0])
    $display("test scaling done");
    defaults();
    for (int i = 0; i < 4; i++) begin
      in_src[i][0] = 3'h1;
      in_src[i][1] = 3'h1;
    end
    op[0][0] = math_eval_pkg::OP_ADD;
    op[1][0] = math_eval_pkg::OP_SUB;
    op[2][0] = math_eval_pkg::OP_MIN;
    op[3][0] = math_eval_pkg::OP_MAX;
    out_min[0] = 0;
    out_max[0] = 1000000;
    src_value[1][0] = 500;
    src_value[1][1] = 100;
    step();
    // 600 on a 0..1e6 range: (1000600*1000000)/2000000
    `CHK("mapped result", 500300, result[0])
    `CHK("range min", 0, range_min[0])
    `CHK("range max", 1000000, range_max[0])
    `CHK("second instance", 400, result[1])
    `CHK("second range min", -1000000, range_min[1])
    `CHK("third instance", 100, result[2])
    `CHK("fourth instance", 500, result[3])
    `CHK("fourth range max", 1000000, range_max[3])
    ce = 1'b0;
    src_value[1][1] = 200;
    step();
    `CHK("held while disabled", 500300, result[0])
    ce = 1'b1;
    step();
    `CHK("recomputed result", 500350, result[0])
    $display("test output range done");
    stop_test();
  end
endmodule : tb
